// ===== src/motion_detector.sv
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "motion_cfg.svh"
module motion_detector
  import motion_pkg::*;
#(
  parameter int SW = 12,
  parameter int TW = 11
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic sample_valid,
  input wire logic [SW-1:0] x_sample,
  input wire logic [SW-1:0] y_sample,
  input wire logic [SW-1:0] z_sample,
  output logic awake_out,
  output logic irq_act,
  output logic irq_inact
);
  logic [8:0] ctrl;
  logic [TW-1:0] act_thr;
  logic [TW-1:0] inact_thr;
  logic [15:0] act_time;
  logic [15:0] inact_time;
  logic act_flag;
  logic inact_flag;
  logic awake;
  logic [15:0] act_cnt;
  logic [15:0] inact_cnt;
  logic act_load;
  logic inact_load;
  logic prev_run;
  logic prev_act_en;
  logic prev_inact_en;
  mode_t mode;
  logic run;
  logic act_active;
  logic inact_active;
  logic act_engage;
  logic inact_engage;
  logic [2:0] axis_act;
  logic [2:0] axis_still;
  logic act_hit;
  logic inact_ok;
  logic act_evt;
  logic inact_evt;
  logic [15:0] act_need;
  logic [15:0] inact_need;
  logic [15:0] next_act_cnt;
  logic [15:0] next_inact_cnt;
  logic stat_rd;
  logic [5:0] ref_we;
  logic [5:0][SW-1:0] ref_wd;
  logic [5:0][SW-1:0] ref_q;
  logic [2:0][SW-1:0] smp;

  assign smp[0] = x_sample;
  assign smp[1] = y_sample;
  assign smp[2] = z_sample;

  always_comb begin
    case (ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO])
      `MODE_CODE_MEASURE: mode = MODE_MEASURE;
      `MODE_CODE_WAKEUP: mode = MODE_WAKEUP;
      default: mode = MODE_STANDBY;
    endcase
  end

  assign run = (mode != MODE_STANDBY); // RL17 RL20
  // In linked mode the awake state picks which detector is armed
  assign act_active = run && ctrl[`CTRL_ACT_EN] && (!ctrl[`CTRL_LINK] || !awake); // RL18
  assign inact_active = run && ctrl[`CTRL_INACT_EN] && (!ctrl[`CTRL_LINK] || awake); // RL18
  assign act_engage = run && ctrl[`CTRL_ACT_EN] && (!prev_run || !prev_act_en); // RL4
  assign inact_engage = run && ctrl[`CTRL_INACT_EN] && (!prev_run || !prev_inact_en);

  function automatic logic [SW:0] mag(input logic [SW:0] d);
    mag = d[SW] ? (~d + 1'b1) : d;
  endfunction

  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      logic [SW:0] s_ext;
      logic [SW:0] act_diff;
      logic [SW:0] inact_diff;
      logic [SW:0] act_mag;
      logic [SW:0] inact_mag;
      logic [SW:0] act_t;
      logic [SW:0] inact_t;
      assign s_ext = {smp[a][SW-1], smp[a]};
      assign act_diff = s_ext - {ref_q[a][SW-1], ref_q[a]};
      assign inact_diff = s_ext - {ref_q[a+3][SW-1], ref_q[a+3]};
      assign act_t = {{(SW+1-TW){1'b0}}, act_thr};
      assign inact_t = {{(SW+1-TW){1'b0}}, inact_thr};
      // Raw magnitude in absolute setting, offset from reference otherwise
      assign act_mag = ctrl[`CTRL_ACT_REF] ? mag(act_diff) : mag(s_ext); // RL2 RL3
      assign inact_mag = ctrl[`CTRL_INACT_REF] ? mag(inact_diff) : mag(s_ext); // RL10
      assign axis_act[a] = ctrl[`CTRL_ACT_REF] ? (act_mag >= act_t) : (act_mag > act_t); // RL3
      assign axis_still[a] = inact_mag < inact_t; // RL11
      // Activity reference reloads all axes; inactivity reference tracks violators
      assign ref_we[a] = sample_valid && run && act_load; // RL4 RL5 RL6
      assign ref_we[a+3] = sample_valid && run && (inact_load ||
                           (ctrl[`CTRL_INACT_REF] && !axis_still[a])); // RL12
      assign ref_wd[a] = smp[a];
      assign ref_wd[a+3] = smp[a];
    end
  endgenerate

  ref_store #(.W(SW), .N(6)) u_ref (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .we(ref_we),
    .wd(ref_wd),
    .q(ref_q)
  );

  assign act_hit = |axis_act; // RL21
  assign inact_ok = &axis_still; // RL21

  always_comb begin
    if (mode == MODE_WAKEUP) begin
      act_need = 16'h0001; // RL8
    end else if (act_time == 16'h0000) begin
      act_need = 16'h0001; // RL7
    end else if (act_time > 16'(`ACT_CNT_MAX)) begin
      act_need = 16'(`ACT_CNT_MAX); // RL7
    end else begin
      act_need = act_time;
    end
    inact_need = (inact_time == 16'h0000) ? 16'h0001 : inact_time; // RL13
  end

  assign next_act_cnt = act_cnt + 16'h0001;
  assign next_inact_cnt = inact_cnt + 16'h0001;
  assign act_evt = sample_valid && act_active && !act_load && act_hit &&
                   (next_act_cnt >= act_need); // RL1
  assign inact_evt = sample_valid && inact_active && !inact_load && inact_ok &&
                     (next_inact_cnt >= inact_need); // RL9 RL10

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_cnt <= 16'h0000;
    end else if (!act_active) begin
      act_cnt <= 16'h0000;
    end else if (sample_valid) begin
      if (act_load || !act_hit || act_evt) begin
        act_cnt <= 16'h0000; // RL1
      end else begin
        act_cnt <= next_act_cnt; // RL1
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      inact_cnt <= 16'h0000;
    end else if (!inact_active) begin
      inact_cnt <= 16'h0000;
    end else if (sample_valid) begin
      if (inact_load || !inact_ok || inact_evt) begin
        inact_cnt <= 16'h0000; // RL14
      end else begin
        inact_cnt <= next_inact_cnt; // RL10 RL13
      end
    end
  end

  // Pending reference captures, taken on the next sample
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_load <= 1'b0;
    end else if (act_engage) begin
      act_load <= 1'b1; // RL4
    end else if (inact_evt && ctrl[`CTRL_LINK]) begin
      act_load <= 1'b1; // RL5
    end else if (act_evt && !ctrl[`CTRL_LINK]) begin
      act_load <= 1'b1; // RL6
    end else if (sample_valid && run) begin
      act_load <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      inact_load <= 1'b0;
    end else if (inact_engage) begin
      inact_load <= 1'b1;
    end else if (sample_valid && run) begin
      inact_load <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_run <= 1'b0;
      prev_act_en <= 1'b0;
      prev_inact_en <= 1'b0;
    end else begin
      prev_run <= run;
      prev_act_en <= ctrl[`CTRL_ACT_EN];
      prev_inact_en <= ctrl[`CTRL_INACT_EN];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awake <= 1'b0;
    end else if (act_evt) begin
      awake <= 1'b1; // RL16 RL19
    end else if (inact_evt) begin
      awake <= 1'b0; // RL16 RL19
    end
  end

  assign stat_rd = rd && (addr == `REG_STATUS);

  // Flags clear on a status read; a new event in that cycle wins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_flag <= 1'b0;
      inact_flag <= 1'b0;
    end else begin
      if (act_evt) begin
        act_flag <= 1'b1; // RL15
      end else if (stat_rd) begin
        act_flag <= 1'b0;
      end
      if (inact_evt) begin
        inact_flag <= 1'b1; // RL15
      end else if (stat_rd) begin
        inact_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_act <= 1'b0;
      irq_inact <= 1'b0;
      awake_out <= 1'b0;
    end else begin
      irq_act <= ctrl[`CTRL_INT_ACT] && (act_flag || act_evt); // RL15
      irq_inact <= ctrl[`CTRL_INT_INACT] && (inact_flag || inact_evt); // RL15
      awake_out <= act_evt || (awake && !inact_evt); // RL16
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `CTRL_RESET;
      act_thr <= `THR_RESET;
      inact_thr <= `THR_RESET;
      act_time <= `TIME_RESET;
      inact_time <= `TIME_RESET;
    end else if (wr) begin
      if (addr == `REG_CTRL) begin
        ctrl <= wdata[8:0];
      end else if (addr == `REG_ACT_THR) begin
        act_thr <= wdata[TW-1:0];
      end else if (addr == `REG_ACT_TIME) begin
        act_time <= wdata;
      end else if (addr == `REG_INACT_THR) begin
        inact_thr <= wdata[TW-1:0];
      end else if (addr == `REG_INACT_TIME) begin
        inact_time <= wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      if (addr == `REG_CTRL) begin
        rdata <= {7'h00, ctrl};
      end else if (addr == `REG_ACT_THR) begin
        rdata <= {{(16-TW){1'b0}}, act_thr};
      end else if (addr == `REG_ACT_TIME) begin
        rdata <= act_time;
      end else if (addr == `REG_INACT_THR) begin
        rdata <= {{(16-TW){1'b0}}, inact_thr};
      end else if (addr == `REG_INACT_TIME) begin
        rdata <= inact_time;
      end else if (addr == `REG_STATUS) begin
        rdata <= {13'h0000, awake, inact_flag, act_flag};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_act_marked;
    act_flag && awake && awake_out;
  endsequence

  a_act_needs_hit: assert property (act_evt |-> act_hit && sample_valid) // RL1
    else $error("activity event without qualifying sample");
  a_wake_one_sample: assert property ( // RL8
    sample_valid && act_active && !act_load && act_hit && mode == MODE_WAKEUP |-> act_evt)
    else $error("wake-up mode missed single-sample activity");
  a_act_effects: assert property (act_evt |=> s_act_marked) // RL15
    else $error("activity event not reflected in flag and awake");
  a_inact_clears: assert property (inact_evt && !act_evt |=> !awake && !awake_out) // RL19
    else $error("inactivity did not clear awake");
  a_standby_quiet: assert property (!run |-> !act_evt && !inact_evt) // RL20
    else $error("event raised in standby");
  a_standby_keeps: assert property (!run && !stat_rd && act_flag |=> act_flag) // RL20
    else $error("pending flag lost in standby");
  a_link_one_armed: assert property (ctrl[`CTRL_LINK] |-> !(act_active && inact_active)) // RL18
    else $error("both detectors armed in linked mode");
  a_inact_restart: assert property ( // RL14
    sample_valid && inact_active && !inact_ok |=> inact_cnt == 16'h0000)
    else $error("motion did not restart inactivity count");
  a_reload_unlinked: assert property ( // RL6
    act_evt && !ctrl[`CTRL_LINK] |=> act_load)
    else $error("activity reference not re-armed");
  a_irq_follow: assert property (act_evt && ctrl[`CTRL_INT_ACT] |=> irq_act) // RL15
    else $error("activity request not raised");
endmodule

// ===== src/motion_cfg.svh
// How it works
// RL1: Activity needs threshold exceeded for duration
// RL2: Absolute activity compares raw sample to threshold
// RL3: Referenced activity compares sample minus reference
// RL4: Capture activity reference when measurement starts
// RL5: Linked: recapture reference after inactivity
// RL6: Unlinked: recapture reference after each activity
// RL7: Activity timer spans one sample to 20 s
// RL8: Wake-up mode uses one-sample activity
// RL9: Inactivity needs stillness for duration
// RL10: Absolute inactivity counts consecutive quiet samples
// RL11: Referenced inactivity: difference strictly below threshold
// RL12: Violating sample replaces inactivity reference
// RL13: Inactivity timer counts up to 65535 samples
// RL14: Any motion restarts the inactivity count
// RL15: Events set flags and may raise requests
// RL16: Awake indicator reports moving or stationary
// RL17: Detection runs in measurement and wake-up
// RL18: Linked mode arms one detector at a time
// RL19: Activity sets awake, inactivity clears it
// RL20: Standby suspends detection, keeps pending flags
// RL21: Evaluate per sample; any axis counts
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH

`define REG_CTRL 4'h0
`define REG_ACT_THR 4'h1
`define REG_ACT_TIME 4'h2
`define REG_INACT_THR 4'h3
`define REG_INACT_TIME 4'h4
`define REG_STATUS 4'h5

`define CTRL_ACT_EN 0
`define CTRL_ACT_REF 1
`define CTRL_INACT_EN 2
`define CTRL_INACT_REF 3
`define CTRL_LINK 4
`define CTRL_MODE_LO 5
`define CTRL_MODE_HI 6
`define CTRL_INT_ACT 7
`define CTRL_INT_INACT 8

`define STAT_ACT 0
`define STAT_INACT 1
`define STAT_AWAKE 2

`define MODE_CODE_MEASURE 2'h1
`define MODE_CODE_WAKEUP 2'h2

`define CTRL_RESET 9'h000
`define THR_RESET 11'h000
`define TIME_RESET 16'h0000

`define ACT_TIME_MAX_S 20
`define ODR_MAX_HZ 400
`define ACT_CNT_MAX (`ACT_TIME_MAX_S * `ODR_MAX_HZ)
`define INACT_CNT_MAX 16'hffff

`endif

// ===== src/motion_pkg.sv
package motion_pkg;
  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_MEASURE,
    MODE_WAKEUP
  } mode_t;
endpackage

// ===== src/ref_store.sv
`timescale 1ns/100ps
// Holds the per-axis reference values; read data come from registers
module ref_store #(
  parameter int W = 12,
  parameter int N = 6
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [N-1:0] we,
  input wire logic [N-1:0][W-1:0] wd,
  output logic [N-1:0][W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ent
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          q[i] <= '0;
        end else if (we[i]) begin
          q[i] <= wd[i];
        end
      end
    end
  endgenerate
endmodule

// ===== dv/host_model.sv
`timescale 1ns/100ps
module host_model (
  input wire logic sys_clk,
  input wire logic [15:0] rdata,
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic put(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    v = rdata;
  endtask
endmodule

// ===== dv/motion_detector_tb.sv
`timescale 1ns/100ps
`include "motion_cfg.svh"
module motion_detector_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sv = 1'b0;
  logic [11:0] xs = 12'h000;
  logic [11:0] ys = 12'h000;
  logic [11:0] zs = 12'h000;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic awake_out;
  logic irq_act;
  logic irq_inact;
  logic [15:0] ctl = 16'h0000;
  logic [15:0] d;
  int at, am, it, im, acnt, icnt, cyc, fails, samples_checked;
  int aref[3];
  int iref[3];
  bit aw, sa, si, fa, fi;

  motion_detector i_motion_detector (
    .sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sample_valid(sv), .x_sample(xs), .y_sample(ys),
    .z_sample(zs), .awake_out(awake_out), .irq_act(irq_act), .irq_inact(irq_inact)
  );
  host_model i_host_model (
    .sys_clk(sys_clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd)
  );

  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic int ab(int v);
    return v < 0 ? -v : v;
  endfunction
  function automatic bit run();
    return ctl[6:5] == 2'h1 || ctl[6:5] == 2'h2;
  endfunction
  function automatic bit aon();
    return run() && ctl[0] && !(ctl[4] && aw);
  endfunction
  function automatic bit ion();
    return run() && ctl[2] && !(ctl[4] && !aw);
  endfunction
  function automatic void arm();
    if (!(run() && ctl[0])) fa = 1;
    if (!(run() && ctl[2])) fi = 1;
    if (!aon()) acnt = 0;
    if (!ion()) icnt = 0;
  endfunction

  task automatic cfg(logic [15:0] c, int a1, int a2, int i1, int i2);
    i_host_model.put(`REG_CTRL, 16'h0000);
    ctl = 16'h0000;
    arm();
    i_host_model.put(`REG_ACT_THR, a1[15:0]);
    i_host_model.put(`REG_ACT_TIME, a2[15:0]);
    i_host_model.put(`REG_INACT_THR, i1[15:0]);
    i_host_model.put(`REG_INACT_TIME, i2[15:0]);
    i_host_model.put(`REG_CTRL, c);
    ctl = c;
    at = a1;
    am = a2;
    it = i1;
    im = i2;
    arm();
  endtask

  task automatic smp(int x, int y, int z);
    int s[3];
    int n;
    bit aa, ia, hit, q;
    s = '{x, y, z};
    aa = aon();
    ia = ion();
    @(posedge sys_clk);
    sv <= 1'b1;
    xs <= x[11:0];
    ys <= y[11:0];
    zs <= z[11:0];
    @(posedge sys_clk);
    sv <= 1'b0;
    if (fa && run()) begin
      aref = s;
      fa = 0;
    end else if (aa) begin
      hit = 0;
      foreach (s[k]) hit |= ctl[1] ? ab(s[k] - aref[k]) >= at : ab(s[k]) > at;
      acnt = hit ? acnt + 1 : 0;
      n = ctl[6] ? 1 : (am < 1 ? 1 : (am > 8000 ? 8000 : am));
      if (acnt >= n) begin
        acnt = 0;
        sa = 1;
        aw = 1;
        if (!ctl[4]) fa = 1;
      end
    end
    if (fi && run()) begin
      iref = s;
      fi = 0;
    end else if (run()) begin
      q = 1;
      foreach (s[k]) begin
        if (ab(ctl[3] ? s[k] - iref[k] : s[k]) >= it) begin
          q = 0;
          if (ctl[3]) iref[k] = s[k];
        end
      end
      if (ia) begin
        icnt = q ? icnt + 1 : 0;
        if (icnt >= (im < 1 ? 1 : im)) begin
          icnt = 0;
          si = 1;
          aw = 0;
          if (ctl[4]) fa = 1;
        end
      end
    end
    arm();
    repeat (2) @(posedge sys_clk);
    chk("awake_out", 16'(aw), 16'(awake_out));
    chk("irq_act", 16'(ctl[7] & sa), 16'(irq_act));
    chk("irq_inact", 16'(ctl[8] & si), 16'(irq_inact));
  endtask

  task automatic rs();
    i_host_model.get(`REG_STATUS, d);
    chk("status", {13'h0000, aw, si, sa}, d);
    sa = 0;
    si = 0;
    @(posedge sys_clk);
    chk("irq_act", 16'h0000, 16'(irq_act));
    chk("irq_inact", 16'h0000, 16'(irq_inact));
  endtask

  task automatic pg(logic [3:0] a, logic [15:0] w, logic [15:0] e);
    i_host_model.put(a, w);
    i_host_model.get(a, d);
    chk("register", e, d);
  endtask

  function automatic int rnd(int v);
    return int'($urandom_range(2 * v, 0)) - v;
  endfunction

  initial begin
    void'($urandom(32'hf736d3c1));
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      i_host_model.get(a[3:0], d);
      chk("reset", 16'h0000, d);
    end
    pg(4'hf, 16'hffff, 16'h0000);
    pg(`REG_ACT_THR, 16'hffff, 16'h07ff);
    pg(`REG_INACT_TIME, 16'hffff, 16'hffff);
    pg(`REG_STATUS, 16'hffff, 16'h0000);
    pg(`REG_CTRL, 16'hffff, 16'h01ff);
    cfg(16'h00a1, 100, 2, 0, 0);
    smp(0, 0, 0);
    smp(200, 0, 0);
    smp(100, 0, 0);
    smp(0, -150, 0);
    smp(0, 0, -200);
    rs();
    cfg(16'h00c1, 100, 5, 0, 0);
    smp(0, 0, 0);
    smp(150, 0, 0);
    rs();
    cfg(16'h00a3, 100, 0, 0, 0);
    smp(500, 500, 500);
    smp(599, 401, 500);
    smp(500, 600, 500);
    rs();
    cfg(16'h0124, 0, 0, 100, 3);
    smp(900, 0, 0);
    smp(99, -99, 0);
    smp(0, 0, 0);
    smp(0, 100, 0);
    repeat (3) smp(-99, 50, 0);
    rs();
    cfg(16'h012c, 0, 0, 100, 3);
    smp(1000, 1000, 1000);
    smp(1099, 901, 1000);
    smp(1100, 1000, 1000);
    smp(1150, 1050, 1000);
    smp(1199, 1000, 1000);
    smp(1101, 1000, 950);
    i_host_model.put(`REG_CTRL, 16'h0100);
    ctl = 16'h0100;
    arm();
    smp(2000, 2000, 2000);
    rs();
    cfg(16'h01b5, 200, 2, 100, 3);
    repeat (8) begin
      repeat (5) smp(rnd(300), rnd(300), rnd(300));
      repeat (5) smp(rnd(60), rnd(60), rnd(60));
      rs();
    end
    final_report();
  end
endmodule
